/* File: hdl/bus_hold_pkg.sv */
`default_nettype none
package bus_hold_pkg;

  // Bus outputs that float together while another master owns the bus.
  typedef struct packed {
    logic [22:0] addr;
    logic upperByteEnN;
    logic lowerByteEnN;
    logic writeNotRead;
    logic dataNotCode;
    logic memNotIo;
    logic lockN;
    logic addrStrobeN;
  } busCtl_t;

  // One 16-bit bus cycle asked for by the core.
  typedef struct packed {
    logic [22:0] addr;
    logic upperByteEnN;
    logic lowerByteEnN;
    logic writeNotRead;
    logic dataNotCode;
    logic memNotIo;
    logic lockSeq;
    logic more;
    logic [15:0] wrData;
  } cycInfo_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_T1 = 3'b001,
    S_T2 = 3'b010,
    S_FLOAT = 3'b011,
    S_HELD = 3'b100
  } holdState_t;

  // Idle bus level, loaded only during reset; between cycles busCtl keeps the last cycle's values except lockN, which is set again at cycle end.
  localparam busCtl_t BUS_IDLE = '{addr: 23'h7FFFFF, upperByteEnN: 1'b0, lowerByteEnN: 1'b0,
    writeNotRead: 1'b0, dataNotCode: 1'b1, memNotIo: 1'b0, lockN: 1'b1, addrStrobeN: 1'b1};
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [2:0] NMI_SYNC_RESET = 3'h0;

endpackage : bus_hold_pkg
`default_nettype wire

/* File: hdl/local_bus_hold_handshake.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RQ1] Float address, enables, data, lock, definition, strobe first, then raise acknowledge.
// [RQ2] Keep the bus granted while the hold request stays high.
// [RQ3] On request drop, clear acknowledge and drive the bus in one clock.
// [RQ4] The other master keeps its request high while it owns the bus.
// [RQ5] Ignore the hold request while reset is high.
// [RQ6] Honour a hold request right after reset, before the first fetch.
// [RQ7] Reset beats hold: bus driven idle, no acknowledge.
// [RQ8] Hold request is an active-high level sampled on the clock.
// [RQ9] While held, only the acknowledge is driven, and it is high.
// [RQ10] Bus pins stay floating for the whole acknowledged interval.
// [RQ11] Remember one interrupt rising edge while held, deliver it after release.
// [RQ12] Never grant while a bus cycle is in progress.
// [RQ13] Defer the grant through any number of wait states.
// [RQ14] Aligned 32-bit access is two locked cycles, no external lock, no grant between.
// [RQ15] Split accesses of two or three cycles are not broken by a grant.
// [RQ16] No grant during a lock-prefixed locked sequence.
// [RQ17] The system should return transfer acknowledge promptly to bound hold latency.
// [RQ18] Ignore transfer acknowledge in the first state, sample it after until seen.
// [RQ19] Outside the held state the acknowledge output is driven low.
module local_bus_hold_handshake (
  input wire logic clk, // 25 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic holdReq, // external master asks for the bus
  input wire logic readyN, // transfer acknowledge, active low
  input wire logic nmiIn, // asynchronous non-maskable interrupt pin
  input wire logic cycReq, // core has a bus cycle pending
  input wire bus_hold_pkg::cycInfo_t cycInfo, // description of the pending cycle
  input wire logic [15:0] dataIn, // data bus input
  output logic busGrantAck, // hold acknowledge
  output bus_hold_pkg::busCtl_t busCtl, // address, enables, definition, lock, strobe
  output logic busOe, // enable for busCtl pins
  output logic [15:0] dataOut, // data bus output
  output logic dataOe, // enable for data pins
  output logic cycAccept, // pulse: pending cycle started
  output logic cycDone, // pulse: cycle ended, rdData valid after a read cycle
  output logic [15:0] rdData, // data latched at the end of a read cycle
  output logic nmiPulse // pulse: interrupt edge for the core
);

  // ==========================================================
  // State machine
  bus_hold_pkg::holdState_t state_reg;
  bus_hold_pkg::holdState_t state_next;
  bus_hold_pkg::cycInfo_t cur_reg;
  logic seqLock_reg;
  logic cycEnd;

  assign cycEnd = (state_reg == bus_hold_pkg::S_T2) && !readyN;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bus_hold_pkg::S_IDLE: begin
        // [RQ6] [RQ12] grant from idle
        // [RQ8] level-sampled request
        // [RQ14] split transfers locked
        if (holdReq && !seqLock_reg) begin
          state_next = bus_hold_pkg::S_FLOAT;
        end else if (cycReq) begin
          state_next = bus_hold_pkg::S_T1;
        end
      end
      // [RQ18] first state ignores ready
      bus_hold_pkg::S_T1: state_next = bus_hold_pkg::S_T2;
      bus_hold_pkg::S_T2: begin
        // [RQ13] wait states defer hold
        if (!readyN) begin
          state_next = bus_hold_pkg::S_IDLE;
        end
      end
      bus_hold_pkg::S_FLOAT: begin
        // [RQ1] float before acknowledge
        state_next = holdReq ? bus_hold_pkg::S_HELD : bus_hold_pkg::S_IDLE;
      end
      bus_hold_pkg::S_HELD: begin
        // [RQ2] hold while request high
        if (!holdReq) begin
          state_next = bus_hold_pkg::S_IDLE;
        end
      end
      default: state_next = bus_hold_pkg::S_IDLE;
    endcase
  end

  // [RQ5] reset masks hold request
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= bus_hold_pkg::S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Locked sequence tracking
  // A cycle marked with more means the core will present the rest of the same
  // transfer; hold stays blocked until the last one of them completes.
  always_ff @(posedge clk) begin
    if (rst) begin
      seqLock_reg <= 1'b0;
    end else if (cycEnd) begin
      // [RQ15] split blocks hold
      // [RQ16] lock prefix blocks hold
      seqLock_reg <= cur_reg.more;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_reg <= '0;
    end else if (state_reg == bus_hold_pkg::S_IDLE && state_next == bus_hold_pkg::S_T1) begin
      cur_reg <= cycInfo;
    end
  end

  // ==========================================================
  // Pin drive and acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      // [RQ7] reset drives idle bus
      busGrantAck <= 1'b0;
      busOe <= 1'b1;
      dataOe <= 1'b0;
    end else begin
      // [RQ3] release in one clock
      // [RQ9] [RQ19] acknowledge only held
      busGrantAck <= (state_next == bus_hold_pkg::S_HELD);
      // [RQ10] float whole hold
      busOe <= !(state_next == bus_hold_pkg::S_FLOAT || state_next == bus_hold_pkg::S_HELD);
      dataOe <= (state_next == bus_hold_pkg::S_T1 && cycInfo.writeNotRead)
        || (state_next == bus_hold_pkg::S_T2 && cur_reg.writeNotRead);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busCtl <= bus_hold_pkg::BUS_IDLE;
      dataOut <= bus_hold_pkg::DATA_RESET;
    end else if (state_reg == bus_hold_pkg::S_IDLE && state_next == bus_hold_pkg::S_T1) begin
      busCtl.addr <= cycInfo.addr;
      busCtl.upperByteEnN <= cycInfo.upperByteEnN;
      busCtl.lowerByteEnN <= cycInfo.lowerByteEnN;
      busCtl.writeNotRead <= cycInfo.writeNotRead;
      busCtl.dataNotCode <= cycInfo.dataNotCode;
      busCtl.memNotIo <= cycInfo.memNotIo;
      busCtl.lockN <= !cycInfo.lockSeq;
      busCtl.addrStrobeN <= 1'b0;
      dataOut <= cycInfo.wrData;
    end else if (state_reg == bus_hold_pkg::S_T1) begin
      busCtl.addrStrobeN <= 1'b1;
    end else if (cycEnd) begin
      // Lock stays asserted across the gap to the next locked cycle.
      busCtl.lockN <= !(cur_reg.lockSeq && cur_reg.more);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cycAccept <= 1'b0;
      cycDone <= 1'b0;
      rdData <= bus_hold_pkg::DATA_RESET;
    end else begin
      cycAccept <= (state_reg == bus_hold_pkg::S_IDLE && state_next == bus_hold_pkg::S_T1);
      cycDone <= cycEnd;
      if (cycEnd && !cur_reg.writeNotRead) begin
        rdData <= dataIn;
      end
    end
  end

  // ==========================================================
  // Interrupt edge capture
  logic [2:0] nmiSync_reg;
  logic nmiLevel_reg;
  logic nmiPend_reg;
  logic nmiRise;
  logic heldNow;

  assign nmiRise = nmiSync_reg[1] && nmiSync_reg[2] && !nmiLevel_reg;
  assign heldNow = (state_next == bus_hold_pkg::S_HELD);

  always_ff @(posedge clk) begin
    if (rst) begin
      nmiSync_reg <= bus_hold_pkg::NMI_SYNC_RESET;
      nmiLevel_reg <= 1'b0;
    end else begin
      nmiSync_reg <= {nmiSync_reg[1:0], nmiIn};
      if (nmiSync_reg[1] == nmiSync_reg[2]) begin
        nmiLevel_reg <= nmiSync_reg[2];
      end
    end
  end

  // Only one edge is kept; the core would not take a second one sooner anyway.
  always_ff @(posedge clk) begin
    if (rst) begin
      nmiPend_reg <= 1'b0;
      nmiPulse <= 1'b0;
    end else begin
      // [RQ11] edge held during hold
      nmiPend_reg <= heldNow && (nmiPend_reg || nmiRise);
      nmiPulse <= !heldNow && (nmiPend_reg || nmiRise);
    end
  end

  // ==========================================================
  // Checks
  float_before_ack_a: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    $rose(busGrantAck) |-> !$past(busOe) && !dataOe) else $error("acknowledge rose before bus floated");
  held_while_req_a: assert property (@(posedge clk) disable iff (rst) // [RQ2]
    busGrantAck && holdReq |=> busGrantAck) else $error("grant dropped while request high");
  release_same_clk_a: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    busGrantAck && !holdReq |=> !busGrantAck && busOe) else $error("release not in one clock");
  reset_idle_a: assert property (@(posedge clk) disable iff (rst) // [RQ7]
    $past(rst) |-> !busGrantAck && busOe && busCtl.addrStrobeN) else $error("reset did not idle bus");
  level_grant_a: assert property (@(posedge clk) disable iff (rst) // [RQ8]
    (state_reg == bus_hold_pkg::S_IDLE && !seqLock_reg && holdReq) ##1 holdReq [*2] |-> ##[0:2] busGrantAck)
    else $error("steady request not granted");
  only_ack_a: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    busGrantAck |-> !busOe && !dataOe) else $error("pins driven while acknowledged");
  no_grant_cycle_a: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    state_reg == bus_hold_pkg::S_T1 |=> !busGrantAck [*2]) else $error("grant inside bus cycle");
  split_locked_a: assert property (@(posedge clk) disable iff (rst) // [RQ15]
    seqLock_reg && state_reg == bus_hold_pkg::S_IDLE |=> state_reg != bus_hold_pkg::S_FLOAT)
    else $error("grant inside split transfer");
  ready_ignored_a: assert property (@(posedge clk) disable iff (rst) // [RQ18]
    state_reg == bus_hold_pkg::S_T1 |=> state_reg == bus_hold_pkg::S_T2 && !cycDone)
    else $error("first state ended cycle");
  nmi_deferred_a: assert property (@(posedge clk) disable iff (rst) // [RQ11]
    nmiPend_reg && !holdReq && busGrantAck |-> ##1 nmiPulse) else $error("held interrupt edge lost");
  ack_low_a: assert property (@(posedge clk) disable iff (rst) // [RQ19]
    state_reg != bus_hold_pkg::S_HELD |-> !busGrantAck) else $error("acknowledge outside hold");

endmodule : local_bus_hold_handshake
`default_nettype wire

/* File: dv/bus_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Far side: another master plus the memory it shares
module bus_master_model (
  input wire logic clk, // bus clock
  output logic holdReq, // asks for the local bus
  output logic readyN, // transfer acknowledge
  output logic [15:0] dataIn // data seen by the device
);
  initial begin
    holdReq = 1'b0;
    readyN = 1'b1;
    dataIn = 16'h0000;
  end
  // Read data churns unless acknowledged, so a latch on the wrong edge is caught.
  always @(posedge clk) begin
    if (readyN) begin
      dataIn <= 16'($urandom);
    end
  end
  task automatic setHold(input logic v);
    holdReq <= v;
  endtask : setHold
  task automatic setReady(input logic v);
    readyN <= v;
  endtask : setReady
endmodule : bus_master_model
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst;
  logic nmiIn;
  logic cycReq;
  bus_hold_pkg::cycInfo_t cycInfo;
  bus_hold_pkg::busCtl_t busCtl;
  logic holdReq, readyN, busGrantAck, busOe, dataOe, cycAccept, cycDone, nmiPulse;
  logic [15:0] dataIn, dataOut, rdData;
  int error_cnt = 0;
  int checked = 0;
  int seed;
  always #20 clk = ~clk;
  bus_master_model i_bm (.clk(clk), .holdReq(holdReq), .readyN(readyN), .dataIn(dataIn));
  local_bus_hold_handshake i_dut (.clk(clk), .rst(rst), .holdReq(holdReq), .readyN(readyN),
    .nmiIn(nmiIn), .cycReq(cycReq), .cycInfo(cycInfo), .dataIn(dataIn), .busGrantAck(busGrantAck),
    .busCtl(busCtl), .busOe(busOe), .dataOut(dataOut), .dataOe(dataOe), .cycAccept(cycAccept),
    .cycDone(cycDone), .rdData(rdData), .nmiPulse(nmiPulse));
  // ==========================================
  // Helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  // Expected {ack, busOe, dataOe} when held or owning the bus.
  function automatic logic [2:0] pins(input logic held);
    return held ? 3'b100 : 3'b010;
  endfunction : pins
  // Expected bus pins in the first state of a cycle.
  function automatic bus_hold_pkg::busCtl_t ctlOf(input bus_hold_pkg::cycInfo_t ci);
    bus_hold_pkg::busCtl_t b;
    b = '{addr: ci.addr, upperByteEnN: ci.upperByteEnN, lowerByteEnN: ci.lowerByteEnN,
      writeNotRead: ci.writeNotRead, dataNotCode: ci.dataNotCode, memNotIo: ci.memNotIo,
      lockN: ~ci.lockSeq, addrStrobeN: 1'b0};
    return b;
  endfunction : ctlOf
  task automatic waitSig(input int sel);
    int k;
    k = 0;
    while ((sel == 0 ? cycAccept : sel == 1 ? cycDone : busGrantAck) !== 1'b1) begin
      step(1);
      k++;
      if (k == 40) begin
        error_cnt++;
        end_of_test();
      end
    end
  endtask : waitSig
  task automatic runCyc(input logic more, input logic lk, input logic hold);
    bus_hold_pkg::cycInfo_t info;
    int w;
    info = 46'({$urandom, $urandom});
    info.more = more;
    info.lockSeq = lk;
    info.lowerByteEnN = info.lowerByteEnN & ~info.upperByteEnN;
    w = 1 + int'($urandom % 6);
    cycInfo <= info;
    cycReq <= 1'b1;
    waitSig(0);
    cycReq <= 1'b0;
    if (hold) begin
      i_bm.setHold(1'b1);
    end
    check({busCtl, dataOe, dataOut}, {ctlOf(info), info.writeNotRead, info.wrData});
    i_bm.setReady(1'b0);
    step(1);
    check({busCtl.addrStrobeN, cycDone}, 2'b10);
    i_bm.setReady(1'b1);
    repeat (w) begin
      step(1);
      check({cycDone, busGrantAck, dataOe}, {2'b00, info.writeNotRead});
    end
    i_bm.setReady(1'b0);
    waitSig(1);
    check({busGrantAck, dataOe, busCtl.lockN}, {2'b00, ~(lk & more)});
    if (!info.writeNotRead) begin
      check(rdData, dataIn);
    end
    i_bm.setReady(1'b1);
  endtask : runCyc
  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    nmiIn = 1'b0;
    cycReq = 1'b0;
    cycInfo = '0;
    seed = $urandom(32'h0657);
    #1;
    i_bm.setHold(1'b1);
    repeat (5) begin
      step(1);
      check({busGrantAck, busOe, dataOe}, pins(1'b0));
      check(busCtl, bus_hold_pkg::BUS_IDLE);
    end
    rst <= 1'b0;
    step(1);
    check({busGrantAck, busOe, dataOe}, 3'b000);
    step(1);
    check({busGrantAck, busOe, dataOe}, pins(1'b1));
    for (int i = 0; i < 16; i++) begin
      nmiIn <= (i % 8) inside {[1:4]};
      step(1);
      check({busGrantAck, busOe, dataOe, nmiPulse}, {pins(1'b1), 1'b0});
    end
    i_bm.setHold(1'b0);
    step(1);
    check({busGrantAck, busOe, nmiPulse}, 3'b011);
    step(1);
    check(nmiPulse, 1'b0);
    // transfers of one to three cycles
    for (int len = 1; len <= 3; len++) begin
      for (int lk = 0; lk < 2; lk++) begin
        for (int c = 0; c < len; c++) begin
          runCyc(c < len - 1, lk[0], c == 0);
        end
        waitSig(2);
        check({busGrantAck, busOe, dataOe}, pins(1'b1));
        i_bm.setHold(1'b0);
        step(1);
      end
    end
    i_bm.setHold(1'b1);
    waitSig(2);
    rst <= 1'b1;
    step(1);
    check({busGrantAck, busOe, dataOe}, pins(1'b0));
    check(busCtl, bus_hold_pkg::BUS_IDLE);
    rst <= 1'b0;
    i_bm.setHold(1'b0);
    step(2);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
